// ===== hdl/plc_ff_next.sv
// Next-state function of the cell register for D, T, JK and SR behaviour.
`timescale 1ns/1ns
module plc_ff_next (
  // Configuration.
  input  wire logic [1:0] ff_type,
  // Present state and data.
  input  wire logic       q,
  input  wire logic       d,
  input  wire logic       k,
  // Next state.
  output logic            next_q
);

  always_comb begin
    next_q = q;
    case (ff_type)
      plc_pkg::PLC_FF_D:  next_q = d;
      plc_pkg::PLC_FF_T:  next_q = q ^ d;
      plc_pkg::PLC_FF_JK: begin
        case ({d, k})
          2'h1:    next_q = 1'b0;
          2'h2:    next_q = 1'b1;
          2'h3:    next_q = ~q;
          default: next_q = q;
        endcase
      end
      plc_pkg::PLC_FF_SR: begin
        case ({d, k})
          2'h1:    next_q = 1'b0;
          2'h2:    next_q = 1'b1;
          default: next_q = q;
        endcase
      end
      default: next_q = q;
    endcase
  end

endmodule

// ===== hdl/plc_logic_cell.sv
// Programmable logic cell with lookup table, register, carry and register chains.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module plc_logic_cell (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Register port.
  input  wire logic [plc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [plc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_write,
  input  wire logic                       reg_read,
  output logic      [plc_pkg::DATA_W-1:0] reg_rdata,
  // Local routing and chain inputs.
  input  wire logic                       data_first,
  input  wire logic                       data_second,
  input  wire logic                       data_third,
  input  wire logic                       fourth_data_input,
  input  wire logic                       carry_in,
  input  wire logic                       reg_chain_in,
  // Cluster-wide controls.
  input  wire logic                       cluster_clock_tick_first,
  input  wire logic                       cluster_clock_tick_second,
  input  wire logic                       cluster_clock_enable_first,
  input  wire logic                       cluster_clock_enable_second,
  input  wire logic                       cluster_clear_first_n,
  input  wire logic                       cluster_clear_second_n,
  input  wire logic                       cluster_sync_load,
  input  wire logic                       cluster_sync_clear,
  // Chip-wide clear pin.
  input  wire logic                       chip_wide_clear_n,
  // Routing and chain outputs.
  output logic      [plc_pkg::ROUTE_N-1:0] route_out,
  output logic                            reg_chain_out,
  output logic                            carry_out
);

  // Whole state of the cell.
  typedef struct packed {
    logic                       clr_meta;
    logic                       clr_sync;
    logic [plc_pkg::DATA_W-1:0] lut_mask;
    logic [plc_pkg::DATA_W-1:0] mode;
    logic                       cell_q;
    logic                       lut_q;
    logic                       carry_q;
    logic [plc_pkg::ROUTE_N-1:0] route_q;
    logic [plc_pkg::DATA_W-1:0] rdata;
  } plc_state_t;

  localparam plc_state_t PLC_STATE_RST = '{
    clr_meta: 1'b1,
    clr_sync: 1'b1,
    lut_mask: plc_pkg::LUT_MASK_RST,
    mode:     plc_pkg::MODE_RST,
    cell_q:   1'b0,
    lut_q:    1'b0,
    carry_q:  1'b0,
    route_q:  3'h0,
    rdata:    16'h0000
  };

  plc_state_t s;
  plc_state_t next_s;

  // Decoded configuration.
  logic                        cfg_arith;
  logic                        cfg_lut4_carry;
  logic                        cfg_pack;
  logic                        cfg_feedback;
  logic                        cfg_chain_start;
  logic [1:0]                  cfg_ff_type;
  logic                        cfg_shift;
  logic [plc_pkg::ROUTE_N-1:0] cfg_outsel;
  logic                        cfg_tick_sel;
  logic                        cfg_ena_sel;
  logic                        cfg_ena_use;
  logic                        cfg_clr_sel;
  logic                        cfg_chip_clr_en;

  // Datapath nets.
  logic                        cin_eff;
  logic                        lut_b;
  logic                        lut_d;
  logic                        lut_out;
  logic                        lut_cout;
  logic                        reg_d;
  logic                        reg_k;
  logic                        ff_next;
  logic                        cell_tick;
  logic                        cell_ena;
  logic                        cell_clear;
  logic                        chip_clear;
  logic                        load_ok;
  logic [plc_pkg::ROUTE_N-1:0] route_next;
  logic [plc_pkg::DATA_W-1:0]  status;

  assign cfg_arith       = s.mode[plc_pkg::MB_ARITH];
  assign cfg_lut4_carry  = s.mode[plc_pkg::MB_LUT4_CARRY];
  assign cfg_pack        = s.mode[plc_pkg::MB_PACK];
  assign cfg_feedback    = s.mode[plc_pkg::MB_FEEDBACK];
  assign cfg_chain_start = s.mode[plc_pkg::MB_CHAIN_START];
  assign cfg_ff_type     = s.mode[plc_pkg::MB_FF_LO +: 2];
  assign cfg_shift       = s.mode[plc_pkg::MB_SHIFT];
  assign cfg_outsel      = s.mode[plc_pkg::MB_OUTSEL_LO +: plc_pkg::ROUTE_N];
  assign cfg_tick_sel    = s.mode[plc_pkg::MB_TICK_SEL];
  assign cfg_ena_sel     = s.mode[plc_pkg::MB_ENA_SEL];
  assign cfg_ena_use     = s.mode[plc_pkg::MB_ENA_USE];
  assign cfg_clr_sel     = s.mode[plc_pkg::MB_CLR_SEL];
  assign cfg_chip_clr_en = s.mode[plc_pkg::MB_CHIP_CLR_EN];

  always_comb begin
    cin_eff = carry_in;
    if (cfg_chain_start) begin
      cin_eff = 1'b0;
    end
    lut_b = data_second;
    if (cfg_feedback) begin
      lut_b = s.cell_q;
    end
    lut_d = fourth_data_input;
    if (!cfg_arith && cfg_lut4_carry) begin
      lut_d = cin_eff;
    end
  end

  plc_lut4 u_lut (
    .mask    (s.lut_mask),
    .arith   (cfg_arith),
    .in_a    (data_first),
    .in_b    (lut_b),
    .in_c    (data_third),
    .in_d    (lut_d),
    .cin     (cin_eff),
    .lut_out (lut_out),
    .cout    (lut_cout)
  );

  always_comb begin
    reg_d = lut_out;
    if (cfg_shift) begin
      reg_d = reg_chain_in;
    end else if (cfg_pack) begin
      reg_d = fourth_data_input;
    end
  end

  // The K and reset inputs of the register share the third data input.
  assign reg_k = data_third;

  plc_ff_next u_ff (
    .ff_type (cfg_ff_type),
    .q       (s.cell_q),
    .d       (reg_d),
    .k       (reg_k),
    .next_q  (ff_next)
  );

  always_comb begin
    cell_tick = cluster_clock_tick_first;
    if (cfg_tick_sel) begin
      cell_tick = cluster_clock_tick_second;
    end
    cell_ena = cluster_clock_enable_first;
    if (cfg_ena_sel) begin
      cell_ena = cluster_clock_enable_second;
    end
    // An unused enable leaves the register stepping on every selected tick.
    if (!cfg_ena_use) begin
      cell_ena = 1'b1;
    end
    cell_clear = !cluster_clear_first_n;
    if (cfg_clr_sel) begin
      cell_clear = !cluster_clear_second_n;
    end
  end

  assign chip_clear = cfg_chip_clr_en && !s.clr_sync;

  assign load_ok = cluster_sync_load && !cfg_pack;

  genvar gi;
  generate
    for (gi = 0; gi < plc_pkg::ROUTE_N; gi++) begin : g_route
      assign route_next[gi] = cfg_outsel[gi] ? s.cell_q : lut_out;
    end
  endgenerate

  always_comb begin
    status = 16'h0000;
    status[plc_pkg::ST_CELL_Q] = s.cell_q;
    status[plc_pkg::ST_LUT]    = s.lut_q;
    status[plc_pkg::ST_CARRY]  = s.carry_q;
    status[plc_pkg::ST_ROUTE_LO +: plc_pkg::ROUTE_N] = s.route_q;
  end

  always_comb begin
    next_s = s;

    // Chip clear pin through two flip-flops.
    // The pin is asynchronous to clk, so only the second stage is ever read.
    next_s.clr_meta = chip_wide_clear_n;
    next_s.clr_sync = s.clr_meta;

    // Register writes.
    if (reg_write) begin
      case (reg_addr)
        plc_pkg::OFS_LUT_MASK: next_s.lut_mask = reg_wdata;
        plc_pkg::OFS_MODE:     next_s.mode     = reg_wdata;
        default:               next_s.mode     = s.mode;
      endcase
    end

    // Read data stand for one cycle only.
    next_s.rdata = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        plc_pkg::OFS_LUT_MASK: next_s.rdata = s.lut_mask;
        plc_pkg::OFS_MODE:     next_s.rdata = s.mode;
        plc_pkg::OFS_STATUS:   next_s.rdata = status;
        default:               next_s.rdata = 16'h0000;
      endcase
    end

    // Chip and cluster clears act on any clk edge and need neither a tick nor an enable; the sync clear needs a tick and, when the enable is used, an enable.
    // clear priority chain.
    if (chip_clear) begin
      next_s.cell_q = 1'b0;
    end else if (cell_clear) begin
      next_s.cell_q = 1'b0;
    end else if (cell_tick && cell_ena) begin
      if (cluster_sync_clear) begin
        next_s.cell_q = 1'b0;
      end else if (load_ok) begin
        next_s.cell_q = fourth_data_input;
      end else begin
        next_s.cell_q = ff_next;
      end
    end else begin
      next_s.cell_q = s.cell_q;
    end

    next_s.lut_q = lut_out;

    next_s.carry_q = 1'b0;
    if (cfg_arith) begin
      next_s.carry_q = lut_cout;
    end

    next_s.route_q = route_next;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= PLC_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign route_out     = s.route_q;
  assign reg_chain_out = s.cell_q;
  assign carry_out     = s.carry_q;
  assign reg_rdata     = s.rdata;

endmodule

// ===== hdl/plc_lut4.sv
// Four-input lookup table with arithmetic split into sum and carry halves.
`timescale 1ns/1ns
module plc_lut4 (
  // Configuration.
  input  wire logic [15:0] mask,
  input  wire logic        arith,
  // Table inputs.
  input  wire logic        in_a,
  input  wire logic        in_b,
  input  wire logic        in_c,
  input  wire logic        in_d,
  input  wire logic        cin,
  // Results.
  output logic             lut_out,
  output logic             cout
);

  logic [3:0] idx4;
  logic [3:0] sum_idx;
  logic [3:0] car_idx;

  always_comb begin
    idx4    = {in_d, in_c, in_b, in_a};
    sum_idx = {1'b0, cin, in_b, in_a};
    car_idx = {1'b1, cin, in_b, in_a};
    lut_out = 1'b0;
    cout    = 1'b0;
    if (arith) begin
      lut_out = mask[sum_idx];
      cout    = mask[car_idx];
    end else begin
      lut_out = mask[idx4];
    end
  end

endmodule

// ===== hdl/plc_pkg.sv
// Package with register map, field positions and reset values of the logic cell.
package plc_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets.
  localparam logic [ADDR_W-1:0] OFS_LUT_MASK = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_MODE     = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 4'h8;

  // Mode register field positions.
  localparam int MB_ARITH       = 0;
  localparam int MB_LUT4_CARRY  = 1;
  localparam int MB_PACK        = 2;
  localparam int MB_FEEDBACK    = 3;
  localparam int MB_CHAIN_START = 4;
  localparam int MB_FF_LO       = 5;
  localparam int MB_SHIFT       = 7;
  localparam int MB_OUTSEL_LO   = 8;
  localparam int MB_TICK_SEL    = 11;
  localparam int MB_ENA_SEL     = 12;
  localparam int MB_ENA_USE     = 13;
  localparam int MB_CLR_SEL     = 14;
  localparam int MB_CHIP_CLR_EN = 15;

  // Status register field positions.
  localparam int ST_CELL_Q   = 0;
  localparam int ST_LUT      = 1;
  localparam int ST_CARRY    = 2;
  localparam int ST_ROUTE_LO = 3;

  // Number of general routing outputs.
  localparam int ROUTE_N = 3;

  // Reset values: mask holds a full adder, sum low and carry high.
  localparam logic [DATA_W-1:0] LUT_MASK_RST = 16'hE896;
  localparam logic [DATA_W-1:0] MODE_RST     = 16'h8000;

  // Register behaviour of the cell, Gray coded.
  typedef enum logic [1:0] {
    PLC_FF_D  = 2'h0,
    PLC_FF_T  = 2'h1,
    PLC_FF_JK = 2'h3,
    PLC_FF_SR = 2'h2
  } plc_ff_t;

endpackage

// ===== sim/plc_logic_cell_assertions.sv
// Port assertions of the logic cell.
`timescale 1ns/1ns
module plc_logic_cell_assertions (
  // Clock and register port.
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [15:0] reg_rdata,
  // Cluster controls.
  input wire logic        cluster_clock_tick_first,
  input wire logic        cluster_clock_tick_second,
  input wire logic        cluster_clock_enable_first,
  input wire logic        cluster_clock_enable_second,
  input wire logic        cluster_clear_first_n,
  input wire logic        cluster_clear_second_n,
  input wire logic        cluster_sync_clear,
  input wire logic        chip_wide_clear_n,
  // Outputs.
  input wire logic [2:0]  route_out,
  input wire logic        reg_chain_out,
  input wire logic        carry_out
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_rst;
    disable iff (1'b0) !resetn |=> route_out == 3'h0 && !reg_chain_out && !carry_out
      && reg_rdata == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");

  property p_hold;
    chip_wide_clear_n [*3] ##0 (!cluster_clock_tick_first && !cluster_clock_tick_second
      && cluster_clear_first_n && cluster_clear_second_n) |=> $stable(reg_chain_out);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without a tick");

  property p_clr;
    !cluster_clear_first_n && !cluster_clear_second_n |=> !reg_chain_out;
  endproperty
  a_clr: assert property (p_clr) else $error("cluster clear ignored");

  property p_sclr;
    cluster_clock_tick_first && cluster_clock_tick_second && cluster_clock_enable_first
      && cluster_clock_enable_second && cluster_sync_clear |=> !reg_chain_out;
  endproperty
  a_sclr: assert property (p_sclr) else $error("synchronous clear ignored");

  property p_stq;
    reg_read && reg_addr == 4'h8 |=> reg_rdata[0] == $past(reg_chain_out);
  endproperty
  a_stq: assert property (p_stq) else $error("status register bit wrong");

  property p_str;
    reg_read && reg_addr == 4'h8 |=> reg_rdata[5:3] == $past(route_out);
  endproperty
  a_str: assert property (p_str) else $error("status route bits wrong");

  property p_stc;
    reg_read && reg_addr == 4'h8 |=> reg_rdata[2] == $past(carry_out);
  endproperty
  a_stc: assert property (p_stc) else $error("status carry bit wrong");

  property p_idle;
    !reg_read |=> reg_rdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without a read");
endmodule

bind plc_logic_cell plc_logic_cell_assertions u_plc_logic_cell_assertions (.*);

// ===== sim/plc_logic_cell_test.sv
// Self-checking bench of the logic cell against a behavioural model.
`timescale 1ns/1ns
module plc_logic_cell_test;
  logic        clk, resetn, chip_n, rw, rr, quiet, chin, cin, chain, cout;
  logic        q, lq, cq, s1, s2;
  logic [2:0]  route, rq;
  logic [3:0]  ra;
  logic [15:0] wd, rdata, mk, md, rdm, m;
  logic [18:0] iv;
  logic [31:0] seed;
  int          failures, n_tests;
  wire         c1n = |iv[10:8];
  wire         c2n = |iv[13:11];
  wire         scl = &iv[16:15];

  plc_logic_cell u_plc_logic_cell (
    .clk(clk), .resetn(resetn), .reg_addr(ra), .reg_wdata(wd), .reg_write(rw),
    .reg_read(rr), .reg_rdata(rdata), .data_first(iv[0]), .data_second(iv[1]),
    .data_third(iv[2]), .fourth_data_input(iv[3]), .carry_in(cin), .reg_chain_in(chin),
    .cluster_clock_tick_first(iv[4]), .cluster_clock_tick_second(iv[5]),
    .cluster_clock_enable_first(iv[6]), .cluster_clock_enable_second(iv[7]),
    .cluster_clear_first_n(c1n), .cluster_clear_second_n(c2n),
    .cluster_sync_load(iv[14]), .cluster_sync_clear(scl), .chip_wide_clear_n(chip_n),
    .route_out(route), .reg_chain_out(chain), .carry_out(cout));
  plc_prev_cell u_plc_prev_cell (.clk(clk), .resetn(resetn), .feed_q(iv[17]),
    .feed_c(iv[18]), .chain_q(chin), .carry_q(cin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic void step();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    rr <= 1'b0;
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
  endtask

  task automatic run(input int n, input logic [18:0] km);
    repeat (n) begin
      @(posedge clk);
      step();
      iv <= seed[18:0] & km;
      rr <= seed[31:29] == 3'h0;
      ra <= seed[23:20];
    end
  endtask

  task automatic chk_out(input logic [4:0] g, input logic [4:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: outputs %b expected %b", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: read data %h expected %h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin : model
    logic b, ci, t, c, dd, nq, go, cl;
    if (!resetn) begin
      mk = plc_pkg::LUT_MASK_RST;
      md = plc_pkg::MODE_RST;
      {q, lq, cq, rq, rdm, s1, s2} = {6'h00, 16'h0000, 2'h3};
    end else begin
      rdm = !rr ? 16'h0000 : ra == 4'h0 ? mk : ra == 4'h4 ? md
          : ra == 4'h8 ? {10'h000, rq, cq, lq, q} : 16'h0000;
      b = md[3] ? q : iv[1];
      ci = md[4] ? 1'b0 : cin;
      dd = (!md[0] && md[1]) ? ci : iv[3];
      t = md[0] ? mk[{1'b0, ci, b, iv[0]}] : mk[{dd, iv[2], b, iv[0]}];
      c = md[0] & mk[{1'b1, ci, b, iv[0]}];
      dd = md[7] ? chin : md[2] ? iv[3] : t;
      nq = md[6:5] == 2'h0 ? dd : md[6:5] == 2'h1 ? q ^ dd : md[6:5] == 2'h3
         ? (dd & !q) | (!iv[2] & q) : (dd & !iv[2]) | (q & !(iv[2] & !dd));
      go = (md[11] ? iv[5] : iv[4]) && (!md[13] || (md[12] ? iv[7] : iv[6]));
      cl = (md[15] && !s2) || !(md[14] ? c2n : c1n);
      nq = cl ? 1'b0 : !go ? q : scl ? 1'b0 : (iv[14] && !md[2]) ? iv[3] : nq;
      for (int i = 0; i < 3; i++) rq[i] = md[8 + i] ? q : t;
      {q, lq, cq, s2, s1} = {nq, t, c, s1, chip_n};
      if (rw && ra == 4'h0) mk = wd;
      if (rw && ra == 4'h4) md = wd;
    end
  end

  always @(negedge clk) begin
    if (resetn && !quiet) begin
      chk_out({route, chain, cout}, {rq, q, cq});
      chk_word(rdata, rdm);
    end
  end

  initial begin
    {resetn, rw, rr, quiet, ra, wd, iv} = '0;
    chip_n = 1'b1;
    seed = 32'h0000003C;
    failures = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rreg(4'h0);
    rreg(4'h4);
    for (int p = 0; p < 48; p++) begin
      step();
      m = seed[15:0];
      m[6:5] = p[1:0];
      m[0] = p[2];
      wreg(4'h0, seed[31:16]);
      wreg(4'h8, seed[15:0]);
      wreg(4'hC, seed[15:0]);
      wreg(4'h4, m);
      run(150, 19'h7FFFF);
    end
    wreg(4'h4, m | 16'h8000);
    chip_n <= 1'b0;
    quiet <= 1'b1;
    run(6, 19'h7FFCF);
    quiet <= 1'b0;
    run(12, 19'h7FFFF);
    chip_n <= 1'b1;
    quiet <= 1'b1;
    run(6, 19'h7FFCF);
    quiet <= 1'b0;
    run(20, 19'h7FFFF);
    print_verdict();
  end

  initial begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule

// ===== sim/plc_prev_cell.sv
// Behavioural previous cell that drives the carry and register chains.
`timescale 1ns/1ns
module plc_prev_cell (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Bench feed.
  input  wire logic feed_q,
  input  wire logic feed_c,
  // Chains to the next cell.
  output logic      chain_q,
  output logic      carry_q
);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      chain_q <= 1'b0;
      carry_q <= 1'b0;
    end else begin
      chain_q <= feed_q;
      carry_q <= feed_c;
    end
  end
endmodule
